// ===== design/pad_bar_decode.sv
`timescale 1ns/10ps
`include "pad_params.svh"

module pad_bar_decode
(
  input  wire logic                     I_MCLK,
  input  wire logic                     I_RESETN,
  input  wire logic                     I_CPU_CFG_EN,
  input  wire logic                     I_CONFIG_DONE,
  input  wire logic [`PAD_MASK_W-1:0]   I_WIN_ONE_MASK,
  input  wire logic [`PAD_MASK_W-1:0]   I_WIN_TWO_MASK,
  input  wire logic [15:0]              I_STS_SET,
  input  wire logic                     I_IRQ_SET,
  input  wire pad_pkg::pad_cfg_req_t    I_CFG,
  input  wire pad_pkg::pad_pci_req_t    I_PCI,
  output logic [31:0]                   O_CFG_RDATA,
  output logic                          O_CFG_RACK,
  output logic [15:0]                   O_CMD,
  output pad_pkg::pad_hit_t             O_HIT,
  output logic                          O_TGT_CLAIM,
  output logic                          O_IRQ_PEND,
  output logic                          O_INTA_N
);
  import pad_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [15:0]                cmd_q;
  logic [15:0]                cmd_d;
  logic [15:0]                sts_q;
  logic [15:0]                sts_d;
  logic [`PAD_WIN_W-1:0]      win_one_q;
  logic [`PAD_WIN_W-1:0]      win_one_d;
  logic [`PAD_WIN_W-1:0]      win_two_q;
  logic [`PAD_WIN_W-1:0]      win_two_d;
  logic [31:`PAD_IO_LSB]      io_location_field_q;
  logic [31:`PAD_IO_LSB]      io_location_field_d;
  logic [31:`PAD_MEM_LSB]     mem_location_field_q;
  logic [31:`PAD_MEM_LSB]     mem_location_field_d;
  logic                       pend_q;
  logic                       pend_d;
  logic [31:0]                rdata_q;
  logic                       rack_q;
  pad_hit_t                   hit_q;
  pad_hit_t                   hit_d;
  logic                       claim_q;
  logic                       inta_n_q;

  // ****************************************************************
  // Byte lane mask
  // ****************************************************************
  logic [31:0] be_mask;
  logic [31:0] wmerge_data;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_lane
      assign be_mask[g*8 +: 8] = {8{I_CFG.be[g]}};
    end
  endgenerate

  assign wmerge_data = I_CFG.wdata & be_mask;

  // ****************************************************************
  // Write decode and permission
  // ****************************************************************
  logic sel_cmd;
  logic sel_win_one;
  logic sel_win_two;
  logic sel_io;
  logic sel_mem;
  logic cond_ok;
  logic host_wr;
  logic base_wr_ok;
  logic wr_cmd;
  logic wr_sts;

  assign sel_cmd     = (I_CFG.addr == `PAD_OFS_CMD_STS);
  assign sel_win_one = (I_CFG.addr == `PAD_OFS_WIN_ONE);
  assign sel_win_two = (I_CFG.addr == `PAD_OFS_WIN_TWO);
  assign sel_io      = (I_CFG.addr == `PAD_OFS_IRQ_IO);
  assign sel_mem     = (I_CFG.addr == `PAD_OFS_IRQ_MEM);

  // Enable bit 1 hands command ownership to exactly one side
  assign cond_ok    = I_CFG.from_cpu ? I_CPU_CFG_EN : ~I_CPU_CFG_EN;
  assign host_wr    = I_CFG.wr & ~I_CFG.from_cpu;
  // Window bases belong to the PCI side only, and only once config is done
  assign base_wr_ok = host_wr & I_CONFIG_DONE;
  assign wr_cmd     = I_CFG.wr & sel_cmd & cond_ok;
  assign wr_sts     = I_CFG.wr & sel_cmd;

  // ****************************************************************
  // Next values
  // ****************************************************************
  // Hardware set beats a same-cycle clear so no event is lost
  assign cmd_d = wr_cmd ?
                 ((cmd_q & ~be_mask[15:0]) | wmerge_data[15:0]) : cmd_q;
  assign sts_d = (sts_q & ~(wr_sts ? wmerge_data[31:`PAD_STS_LSB]
                                   : 16'h0000))
                 | I_STS_SET;

  // Low constant fields are never stored, so writes to them vanish
  assign win_one_d = (base_wr_ok & sel_win_one) ?
                     ((win_one_q & ~be_mask[31:`PAD_WIN_LSB]) |
                      wmerge_data[31:`PAD_WIN_LSB]) : win_one_q;
  assign win_two_d = (base_wr_ok & sel_win_two) ?
                     ((win_two_q & ~be_mask[31:`PAD_WIN_LSB]) |
                      wmerge_data[31:`PAD_WIN_LSB]) : win_two_q;
  assign io_location_field_d = (host_wr & sel_io) ?
                     ((io_location_field_q & ~be_mask[31:`PAD_IO_LSB]) |
                      wmerge_data[31:`PAD_IO_LSB])
                     : io_location_field_q;
  assign mem_location_field_d = (host_wr & sel_mem) ?
                     ((mem_location_field_q & ~be_mask[31:`PAD_MEM_LSB]) |
                      wmerge_data[31:`PAD_MEM_LSB])
                     : mem_location_field_q;

  // ****************************************************************
  // Read mux
  // ****************************************************************
  logic [31:0] rd_mux;

  assign rd_mux =
    sel_cmd     ? {sts_q, cmd_q} :
    sel_win_one ? {win_one_q, `PAD_WIN_LOW} :
    sel_win_two ? {win_two_q, `PAD_WIN_LOW} :
    sel_io      ? {io_location_field_q, `PAD_IO_SPACE} :
    sel_mem     ? {mem_location_field_q, `PAD_MEM_SPACE} :
                  32'h00000000;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic [`PAD_WIN_W-1:0] addr_top;
  logic                  win_one_hit;
  logic                  win_two_hit;
  logic                  io_hit;
  logic                  mem_hit;
  logic                  irq_wr_hit;

  // Only the top address bits take part; low constant field excluded
  assign addr_top = I_PCI.addr[31:`PAD_WIN_LSB];

  pad_win_match u_win_one
  (
    .i_base     (win_one_q),
    .i_mask     (I_WIN_ONE_MASK),
    .i_addr_top (addr_top),
    .o_hit      (win_one_hit)
  );

  pad_win_match u_win_two
  (
    .i_base     (win_two_q),
    .i_mask     (I_WIN_TWO_MASK),
    .i_addr_top (addr_top),
    .o_hit      (win_two_hit)
  );

  // A zero location would alias address 0, so it is treated as unset
  assign io_hit  = I_PCI.is_io &&
                   (io_location_field_q != `PAD_IO_RST) &&
                   (I_PCI.addr[31:`PAD_IO_LSB] == io_location_field_q);
  assign mem_hit = ~I_PCI.is_io &&
                   (mem_location_field_q != `PAD_MEM_RST) &&
                   (I_PCI.addr[31:`PAD_MEM_LSB] == mem_location_field_q);

  assign hit_d.win_one = I_PCI.valid & ~I_PCI.is_io & win_one_hit;
  assign hit_d.win_two = I_PCI.valid & ~I_PCI.is_io & win_two_hit;
  assign hit_d.irq_io  = I_PCI.valid & io_hit;
  assign hit_d.irq_mem = I_PCI.valid & mem_hit;

  // Any value written to the pending bit drops the line; a same-cycle I_IRQ_SET beats it
  assign irq_wr_hit = I_PCI.valid & I_PCI.is_write & (io_hit | mem_hit);
  assign pend_d     = I_IRQ_SET | (pend_q & ~irq_wr_hit);

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RESETN)
    begin
      cmd_q                <= `PAD_CMD_RST;
      sts_q                <= `PAD_STS_RST;
      win_one_q            <= `PAD_WIN_RST;
      win_two_q            <= `PAD_WIN_RST;
      io_location_field_q  <= `PAD_IO_RST;
      mem_location_field_q <= `PAD_MEM_RST;
      pend_q               <= 1'b0;
    end
    else
    begin
      cmd_q                <= cmd_d;
      sts_q                <= sts_d;
      win_one_q            <= win_one_d;
      win_two_q            <= win_two_d;
      io_location_field_q  <= io_location_field_d;
      mem_location_field_q <= mem_location_field_d;
      pend_q               <= pend_d;
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RESETN)
    begin
      rdata_q <= 32'h00000000;
      rack_q  <= 1'b0;
      hit_q   <= '0;
      claim_q <= 1'b0;
      // Line is active low, so it idles high out of reset
      inta_n_q <= 1'b1;
    end
    else
    begin
      rdata_q <= I_CFG.rd ? rd_mux : 32'h00000000;
      rack_q  <= I_CFG.rd;
      hit_q   <= hit_d;
      claim_q <= |hit_d;
      inta_n_q <= ~pend_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign O_CFG_RDATA = rdata_q;
  assign O_CFG_RACK  = rack_q;
  assign O_CMD       = cmd_q;
  assign O_HIT       = hit_q;
  assign O_TGT_CLAIM = claim_q;
  assign O_IRQ_PEND  = pend_q;
  assign O_INTA_N    = inta_n_q;

endmodule // pad_bar_decode

// ===== design/pad_params.svh
// Notes on behaviour
// - CPU side writes command if enable bit 1 is 1, else only the host.
// - Hardware alone sets status bits; a written 1 clears, a 0 keeps.
// - Once config-done is 1 the host programs both bases, used for decode.
// - Reset clears both window base registers to zero.
// - Bits 20:0 of each window base read as 0x8, prefetchable memory.
// - The constant low field of a window base is left out of the compare.
// - Base bits 31:21 match address bits 31:21, bits 27:21 under mask 19:13.
// - A window base with an all-zero address field decodes nothing.
// - Bits 1:0 of the interrupt register I/O base read as the constant 01.
// - I/O base bits 31:2 hold the interrupt register I/O address.
// - Bits 3:0 of the interrupt register memory base read as zero.
// - Memory base bits 31:4 hold the interrupt register memory alias.
// - Any host write to the pending bit negates the interrupt A line unless a set arrives in the same cycle.
`ifndef PAD_PARAMS_SVH
`define PAD_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PAD_OFS_CMD_STS   9'h104
`define PAD_OFS_WIN_ONE   9'h114
`define PAD_OFS_WIN_TWO   9'h118
`define PAD_OFS_IRQ_IO    9'h11C
`define PAD_OFS_IRQ_MEM   9'h120

// ****************************************************************
// Field positions and widths
// ****************************************************************
`define PAD_WIN_LSB       21
`define PAD_WIN_W         11
`define PAD_MASK_W        7
`define PAD_IO_LSB        2
`define PAD_MEM_LSB       4
`define PAD_STS_LSB       16

// ****************************************************************
// Reset and constant values
// ****************************************************************
`define PAD_CMD_RST       16'h0000
`define PAD_STS_RST       16'h0280
`define PAD_WIN_RST       11'h000
`define PAD_WIN_LOW       21'h000008
`define PAD_IO_RST        30'h00000000
`define PAD_IO_SPACE      2'h1
`define PAD_MEM_RST       28'h0000000
`define PAD_MEM_SPACE     4'h0

`endif

// ===== design/pad_pkg.sv
package pad_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        from_cpu;
    logic [8:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pad_cfg_req_t;

  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic        is_write;
    logic [31:0] addr;
  } pad_pci_req_t;

  typedef struct packed {
    logic win_one;
    logic win_two;
    logic irq_io;
    logic irq_mem;
  } pad_hit_t;

endpackage

// ===== design/pad_win_match.sv
`timescale 1ns/10ps
`include "pad_params.svh"

module pad_win_match
(
  input  wire logic [`PAD_WIN_W-1:0]  i_base,
  input  wire logic [`PAD_MASK_W-1:0] i_mask,
  input  wire logic [`PAD_WIN_W-1:0]  i_addr_top,
  output logic                        o_hit
);

  logic [`PAD_WIN_W-1:0] ign;
  logic                  enabled;

  // Mask bit set widens the window: 2 MB up to 256 MB
  assign ign     = {4'h0, i_mask};
  assign enabled = (i_base != `PAD_WIN_RST);
  assign o_hit   = enabled &&
                   ((i_addr_top | ign) == (i_base | ign));

endmodule // pad_win_match

// ===== verif/pad_bar_decode_assertions.sv
`timescale 1ns/10ps
// ****
// Port checks
// ****
module pad_bar_decode_chk
  import pad_pkg::*;
(
  input wire logic                  I_MCLK,
  input wire logic                  I_RESETN,
  input wire logic                  I_IRQ_SET,
  input wire pad_pkg::pad_cfg_req_t I_CFG,
  input wire pad_pkg::pad_pci_req_t I_PCI,
  input wire logic [31:0]           O_CFG_RDATA,
  input wire logic                  O_CFG_RACK,
  input wire pad_pkg::pad_hit_t     O_HIT,
  input wire logic                  O_TGT_CLAIM,
  input wire logic                  O_IRQ_PEND,
  input wire logic                  O_INTA_N
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESETN);
  win_low_a: assert property (I_CFG.rd && (I_CFG.addr == 9'h114 ||
    I_CFG.addr == 9'h118) |=> O_CFG_RACK && O_CFG_RDATA[20:0] == 21'h8)
    else $error("window low field wrong");
  io_low_a: assert property (I_CFG.rd && I_CFG.addr == 9'h11C
    |=> O_CFG_RACK && O_CFG_RDATA[1:0] == 2'h1)
    else $error("io base low field wrong");
  mem_low_a: assert property (I_CFG.rd && I_CFG.addr == 9'h120
    |=> O_CFG_RACK && O_CFG_RDATA[3:0] == 4'h0)
    else $error("mem base low field wrong");
  claim_is_or_a: assert property (O_TGT_CLAIM == (|O_HIT))
    else $error("claim differs from hits");
  idle_no_hit_a: assert property (!I_PCI.valid |=> O_HIT == 4'h0)
    else $error("hit without request");
  io_space_a: assert property (O_HIT.irq_io
    |-> $past(I_PCI.valid) && $past(I_PCI.is_io))
    else $error("io hit on memory");
  mem_space_a: assert property (O_HIT.win_one || O_HIT.win_two ||
    O_HIT.irq_mem |-> !$past(I_PCI.is_io)) else $error("memory hit on io");
  inta_level_a: assert property (O_INTA_N == !O_IRQ_PEND)
    else $error("interrupt line disagrees with pending");
  irq_set_a: assert property (I_IRQ_SET |=> O_IRQ_PEND)
    else $error("pending not set");
  irq_clear_a: assert property ($fell(O_IRQ_PEND)
    |-> $past(I_PCI.valid) && $past(I_PCI.is_write))
    else $error("pending lost");
endmodule // pad_bar_decode_chk

bind pad_bar_decode pad_bar_decode_chk u_chk (.*);

// ===== verif/pad_host_model.sv
`timescale 1ns/10ps
// ****
// Host side of config and PCI
// ****
module pad_host_model
  import pad_pkg::*;
(
  input  wire logic    i_clk,
  output pad_cfg_req_t o_cfg,
  output pad_pci_req_t o_pci
);
  initial
  begin
    o_cfg = '0;
    o_pci = '0;
  end
  // Released lanes are inverted so stale data cannot pass
  task automatic wr(input logic c, input logic [8:0] a,
    input logic [3:0] b, input logic [31:0] d);
    @(negedge i_clk);
    o_cfg = '{1'b1, 1'b0, c, a, b, d};
    @(negedge i_clk);
    o_cfg.wr = 1'b0;
    o_cfg.wdata = ~d;
  endtask
  task automatic rd(input logic [8:0] a);
    @(negedge i_clk);
    o_cfg.rd = 1'b1;
    o_cfg.addr = a;
    @(negedge i_clk);
    o_cfg.rd = 1'b0;
    o_cfg.addr = ~a;
  endtask
  task automatic pci(input logic io, input logic w,
    input logic [31:0] a);
    @(negedge i_clk);
    o_pci = '{1'b1, io, w, a};
    @(negedge i_clk);
    o_pci.valid = 1'b0;
    o_pci.addr = ~a;
  endtask
endmodule // pad_host_model

// ===== verif/pad_bar_decode_tb.sv
`timescale 1ns/10ps
module pad_bar_decode_tb;
  import pad_pkg::*;
  `define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin \
    num_errors++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
  logic clk, rst_n, en, done, irq, rack, claim, pend, inta_n;
  logic [6:0]   m1, m2;
  logic [15:0]  sts, cmd;
  logic [31:0]  rdata;
  pad_cfg_req_t cfg;
  pad_pci_req_t pci;
  pad_hit_t     hit;
  int           num_errors, tests_run;
  pad_bar_decode dut (.I_MCLK(clk), .I_RESETN(rst_n), .I_CPU_CFG_EN(en),
    .I_CONFIG_DONE(done), .I_WIN_ONE_MASK(m1), .I_WIN_TWO_MASK(m2),
    .I_STS_SET(sts), .I_IRQ_SET(irq), .I_CFG(cfg), .I_PCI(pci),
    .O_CFG_RDATA(rdata), .O_CFG_RACK(rack), .O_CMD(cmd), .O_HIT(hit),
    .O_TGT_CLAIM(claim), .O_IRQ_PEND(pend), .O_INTA_N(inta_n));
  pad_host_model u_host (.i_clk(clk), .o_cfg(cfg), .o_pci(pci));
  // ****
  // Helpers
  // ****
  task automatic crd(input logic [8:0] a, input logic [31:0] e);
    u_host.rd(a);
    `CHK({rack, rdata}, {1'b1, e})
  endtask
  task automatic cpci(input logic io, input logic w, input logic [31:0] a,
    input logic [3:0] e);
    u_host.pci(io, w, a);
    `CHK({hit, claim}, {e, |e})
  endtask
  task automatic pulse_irq;
    irq = 1'b1;
    @(negedge clk);
    irq = 1'b0;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    crd(9'h114, 32'h00000008);
    crd(9'h118, 32'h00000008);
    crd(9'h11C, 32'h00000001);
    crd(9'h120, 32'h00000000);
    crd(9'h104, 32'h02800000);
    crd(9'h100, 32'h00000000);
    cpci(1'b0, 1'b0, 32'h00000000, 4'h0);
  endtask
  task automatic t_win;
    u_host.wr(1'b0, 9'h114, 4'hF, 32'hFFE00000);
    crd(9'h114, 32'h00000008);
    done = 1'b1;
    u_host.wr(1'b1, 9'h114, 4'hF, 32'hFFE00000);
    crd(9'h114, 32'h00000008);
    u_host.wr(1'b0, 9'h114, 4'hF, 32'hFFFFFFFF);
    crd(9'h114, 32'hFFE00008);
    u_host.wr(1'b0, 9'h118, 4'hF, 32'h10000000);
    crd(9'h118, 32'h10000008);
    cpci(1'b0, 1'b0, 32'hFFE00000, 4'h8);
    cpci(1'b0, 1'b0, 32'hFFDFFFFC, 4'h0);
    cpci(1'b1, 1'b0, 32'hFFE00000, 4'h0);
    cpci(1'b0, 1'b1, 32'h101FFFFC, 4'h4);
    cpci(1'b0, 1'b0, 32'h10200000, 4'h0);
    m1 = 7'h01;
    cpci(1'b0, 1'b0, 32'hFFC00000, 4'h8);
    m1 = 7'h7F;
    m2 = 7'h7F;
    cpci(1'b0, 1'b0, 32'hF0000000, 4'h8);
    cpci(1'b0, 1'b0, 32'hE0000000, 4'h0);
    cpci(1'b0, 1'b0, 32'h1FFFFFFC, 4'h4);
    u_host.wr(1'b0, 9'h118, 4'hF, 32'h00000000);
    cpci(1'b0, 1'b0, 32'h00000000, 4'h0);
    m1 = 7'h00;
    m2 = 7'h00;
  endtask
  task automatic t_irq;
    u_host.wr(1'b0, 9'h11C, 4'hF, 32'h00001002);
    crd(9'h11C, 32'h00001001);
    u_host.wr(1'b0, 9'h120, 4'hF, 32'h2000000F);
    crd(9'h120, 32'h20000000);
    pulse_irq();
    `CHK({pend, inta_n}, 2'h2)
    cpci(1'b1, 1'b0, 32'h00001000, 4'h2);
    `CHK({pend, inta_n}, 2'h2)
    cpci(1'b1, 1'b1, 32'h00001000, 4'h2);
    `CHK({pend, inta_n}, 2'h1)
    cpci(1'b0, 1'b0, 32'h00001000, 4'h0);
    pulse_irq();
    `CHK({pend, inta_n}, 2'h2)
    cpci(1'b0, 1'b1, 32'h2000000C, 4'h1);
    `CHK({pend, inta_n}, 2'h1)
  endtask
  task automatic t_cmd;
    u_host.wr(1'b1, 9'h104, 4'h3, 32'h00001234);
    `CHK(cmd, 16'h0000)
    u_host.wr(1'b0, 9'h104, 4'h3, 32'h00001234);
    `CHK(cmd, 16'h1234)
    en = 1'b1;
    u_host.wr(1'b0, 9'h104, 4'h3, 32'h00005678);
    `CHK(cmd, 16'h1234)
    u_host.wr(1'b1, 9'h104, 4'h3, 32'h00005678);
    `CHK(cmd, 16'h5678)
    sts = 16'h8000;
    @(negedge clk);
    sts = 16'h0000;
    crd(9'h104, 32'h82805678);
    u_host.wr(1'b0, 9'h104, 4'hC, 32'h00000000);
    crd(9'h104, 32'h82805678);
    u_host.wr(1'b0, 9'h104, 4'hC, 32'h80000000);
    crd(9'h104, 32'h02805678);
  endtask
  task automatic stop_test;
    $display("errors %0d comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  initial
  begin
    {num_errors, tests_run} = '0;
    {rst_n, en, done, irq, m1, m2, sts} = '0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_win();
    t_irq();
    t_cmd();
    stop_test();
  end
endmodule // pad_bar_decode_tb
